// file: src/sasc_pkg.sv
// Constants and carrier types for the serial conversion controller
package sasc_pkg;

    // Result word and conversion cycle numbering
    localparam int unsigned RESULT_WIDTH = 12;
    localparam logic [3:0]  CNT_FIRST    = 4'h1;
    localparam logic [3:0]  CNT_LAST     = 4'hD;
    localparam logic [3:0]  CNT_STEP     = 4'h1;
    localparam logic [3:0]  BIT_BASE     = 4'hC;

    // Timing: reference clock and hold droop limit
    localparam int unsigned REF_PERIOD_NS        = 10;
    localparam int unsigned HOLD_DROOP_LIMIT_US  = 5;
    localparam int unsigned HOLD_DROOP_LIMIT_CYC =
        (HOLD_DROOP_LIMIT_US * 1000) / REF_PERIOD_NS;
    localparam int unsigned DROOP_W              = 9;
    localparam logic [DROOP_W-1:0] DROOP_ONE     = 9'h001;
    localparam logic [DROOP_W-1:0] DROOP_ZERO    = 9'h000;

    // Converter modes
    typedef enum logic [2:0] {
        ST_SAMPLE,
        ST_HOLD,
        ST_CONVERT,
        ST_POWER_DOWN
    } sasc_state_t;

    // Host-side pins
    typedef struct packed {
        logic sample_hold_strobe;
        logic sample_hold_strobe_clk;
    } sasc_pins_in_t;

    // Three-state serial data pin
    typedef struct packed {
        logic data;
        logic oe;
    } sasc_serial_t;

    localparam sasc_serial_t SERIAL_OFF = '{data: 1'b0, oe: 1'b0};

endpackage

// file: src/sasc_sample_hold_strobe_ctl.sv
// Conversion sequencing and serial result output of the sampling converter
`timescale 1ns/1ns

// What this block does, and what its host must do
// R1 - Strobe fall enters hold, ignoring clock
// R2 - Sampling needs no clock edges
// R3 - Clock may park either level afterwards
// R4 - Late strobe shifts start one cycle
// R5 - First conversion cycle drives data low
// R6 - Host avoids clock edges before strobe
// R7 - Host uses synchronous or gated clocking
// R8 - Host starts clocking within droop limit
// R9 - Strobe low at cycle thirteen: power-down
// R10 - First conversion after power-down valid
// R11 - Host holds strobe high for acquisition
// R12 - Fourteen or padded clock periods per cycle
// R13 - Early strobe rise skips power-down
// R14 - Result shifted out MSB first, no latency
// R15 - Result word is straight binary
// R16 - Host counts falling edges, captures bits
module sasc_sample_hold_strobe_ctl #(
    parameter int unsigned WIDTH = sasc_pkg::RESULT_WIDTH
) (
    // Clock, reset, enable
    input  wire logic                 i_ref_clk,
    input  wire logic                 i_reset,
    input  wire logic                 i_ce,
    // Host pins and analog result
    input  wire sasc_pkg::sasc_pins_in_t i_pins,
    input  wire logic [WIDTH-1:0]     i_sample_word,
    // Serial output and status
    output sasc_pkg::sasc_serial_t    o_serial,
    output logic                      o_hold,
    output logic                      o_power_down,
    output logic                      o_droop_late
);
    import sasc_pkg::*;

    sasc_state_t          state_q,      state_d;
    logic [3:0]           cnt_q,        cnt_d;
    logic [WIDTH-1:0]     word_q,       word_d;
    logic                 rose_q,       rose_d;
    logic                 pd_q,         pd_d;
    logic                 hold_q,       hold_d;
    logic                 late_q,       late_d;
    logic [DROOP_W-1:0]   droop_q,      droop_d;
    sasc_serial_t         ser_q,        ser_d;
    logic                 strobe_prev_q;
    logic                 clk_prev_q;
    logic                 fall;
    logic                 rise;
    logic                 clk_fall;

    function automatic logic fell(input logic prev, input logic cur);
        fell = prev & ~cur;
    endfunction

    // Pins are taken as synchronous; edges come from one stored sample
    assign fall     = fell(strobe_prev_q, i_pins.sample_hold_strobe);
    assign rise     = fell(i_pins.sample_hold_strobe, strobe_prev_q);
    assign clk_fall = fell(clk_prev_q, i_pins.sample_hold_strobe_clk);

    always_comb
    begin
        state_d = state_q;
        cnt_d   = cnt_q;
        word_d  = word_q;
        rose_d  = rose_q;
        pd_d    = pd_q;
        hold_d  = hold_q;
        late_d  = late_q;
        droop_d = droop_q;
        ser_d   = ser_q;
        unique case (state_q)
            ST_SAMPLE:
            begin
                ser_d  = SERIAL_OFF;
                hold_d = 1'b0;
                // R1 - hold on strobe fall
                // R2 - no clock needed here
                if (fall)
                begin
                    state_d = ST_HOLD;
                    hold_d  = 1'b1;
                    word_d  = i_sample_word;
                    rose_d  = 1'b0;
                    droop_d = DROOP_ZERO;
                    late_d  = 1'b0;
                end
            end
            ST_HOLD:
            begin
                // Diagnostic only: the host owns the droop bound
                if (droop_q < DROOP_W'(HOLD_DROOP_LIMIT_CYC))
                begin
                    droop_d = droop_q + DROOP_ONE;
                end
                else
                begin
                    late_d = 1'b1;
                end
                if (rise)
                begin
                    state_d = ST_SAMPLE;
                    hold_d  = 1'b0;
                end
                // R4 - first clock fall seen starts
                // R5 - drive low at start
                else if (clk_fall)
                begin
                    state_d = ST_CONVERT;
                    cnt_d   = CNT_FIRST;
                    ser_d   = '{data: 1'b0, oe: 1'b1};
                end
            end
            ST_CONVERT:
            begin
                // R10 - rise leaves power-down at once
                if (rise)
                begin
                    rose_d = 1'b1;
                    pd_d   = 1'b0;
                end
                if (clk_fall)
                begin
                    if (cnt_q == CNT_LAST)
                    begin
                        ser_d   = SERIAL_OFF;
                        hold_d  = 1'b0;
                        // R13 - early rise returns to sampling
                        state_d = (pd_q && !rise) ? ST_POWER_DOWN : ST_SAMPLE;
                    end
                    else
                    begin
                        cnt_d = cnt_q + CNT_STEP;
                        // R14 - MSB first, current word
                        // R15 - straight binary bits
                        ser_d = '{data: word_q[BIT_BASE - cnt_q], oe: 1'b1};
                        // R9 - strobe low throughout
                        if ((cnt_d == CNT_LAST) && !rose_q && !rise
                            && !i_pins.sample_hold_strobe)
                        begin
                            pd_d = 1'b1;
                        end
                    end
                end
            end
            ST_POWER_DOWN:
            begin
                ser_d  = SERIAL_OFF;
                hold_d = 1'b0;
                // R10 - no penalty on wake
                if (rise)
                begin
                    state_d = ST_SAMPLE;
                    pd_d    = 1'b0;
                end
            end
        endcase
    end

    always_ff @(posedge i_ref_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            state_q       <= ST_SAMPLE;
            cnt_q         <= CNT_FIRST;
            word_q        <= '0;
            rose_q        <= 1'b0;
            pd_q          <= 1'b0;
            hold_q        <= 1'b0;
            late_q        <= 1'b0;
            droop_q       <= DROOP_ZERO;
            ser_q         <= SERIAL_OFF;
            strobe_prev_q <= 1'b1;
            clk_prev_q    <= 1'b0;
        end
        else if (i_ce)
        begin
            state_q       <= state_d;
            cnt_q         <= cnt_d;
            word_q        <= word_d;
            rose_q        <= rose_d;
            pd_q          <= pd_d;
            hold_q        <= hold_d;
            late_q        <= late_d;
            droop_q       <= droop_d;
            ser_q         <= ser_d;
            strobe_prev_q <= i_pins.sample_hold_strobe;
            clk_prev_q    <= i_pins.sample_hold_strobe_clk;
        end
    end

    assign o_serial     = ser_q;
    assign o_hold       = hold_q;
    assign o_power_down = pd_q;
    assign o_droop_late = late_q;

    // R1 - hold check
    a_fall_to_hold: assert property (@(posedge i_ref_clk) disable iff (i_reset) // R1
        (state_q == ST_SAMPLE && i_ce && fall) |=> (o_hold && state_q == ST_HOLD))
        else $error("strobe fall did not enter hold");

    // R2 - sampling without clock
    a_sample_stays: assert property (@(posedge i_ref_clk) disable iff (i_reset) // R2
        (state_q == ST_SAMPLE && !(i_ce && fall)) |=> (state_q == ST_SAMPLE && !o_serial.oe))
        else $error("left sampling without a strobe fall");

    // R4 - start on first edge
    a_start_edge: assert property (@(posedge i_ref_clk) disable iff (i_reset) // R4
        (state_q == ST_HOLD && i_ce && clk_fall && !rise) |=>
        (state_q == ST_CONVERT && cnt_q == CNT_FIRST))
        else $error("conversion did not start on clock fall");

    // R5 - start marker low
    a_first_low: assert property (@(posedge i_ref_clk) disable iff (i_reset) // R5
        (state_q == ST_HOLD && i_ce && clk_fall && !rise) |=> (o_serial.oe && !o_serial.data))
        else $error("data not driven low at conversion start");

    // R14 - MSB after marker
    a_msb_first: assert property (@(posedge i_ref_clk) disable iff (i_reset) // R14
        (state_q == ST_CONVERT && i_ce && clk_fall && cnt_q == CNT_FIRST) |=>
        (o_serial.oe && o_serial.data == word_q[WIDTH-1]))
        else $error("first result bit is not the MSB");

    // R15 - LSB in last cycle
    a_lsb_last: assert property (@(posedge i_ref_clk) disable iff (i_reset) // R15
        (state_q == ST_CONVERT && i_ce && clk_fall && cnt_q == CNT_LAST - CNT_STEP) |=>
        (o_serial.oe && o_serial.data == word_q[0] && cnt_q == CNT_LAST))
        else $error("last result bit is not the LSB");

    // R9 - power-down entry
    a_pd_entry: assert property (@(posedge i_ref_clk) disable iff (i_reset) // R9
        (state_q == ST_CONVERT && i_ce && clk_fall && cnt_q == CNT_LAST - CNT_STEP
         && !rose_q && !rise && !i_pins.sample_hold_strobe) |=> o_power_down)
        else $error("power-down not entered at cycle thirteen");

    // R13 - no power-down after rise
    a_no_pd_rise: assert property (@(posedge i_ref_clk) disable iff (i_reset) // R13
        (state_q == ST_CONVERT && rose_q) |-> !o_power_down)
        else $error("power-down after early strobe rise");

    // R10 - wake to sampling
    a_pd_exit: assert property (@(posedge i_ref_clk) disable iff (i_reset) // R10
        (state_q == ST_POWER_DOWN && i_ce && rise) |=>
        (state_q == ST_SAMPLE && !o_power_down) ##1 (state_q != ST_POWER_DOWN))
        else $error("strobe rise did not leave power-down");

endmodule // sasc_sample_hold_strobe_ctl

// file: verification/sasc_host_model.sv
// Host serial port model: strobes, gates the clock, collects result bits
`timescale 1ns/1ns
module sasc_host_model
    import sasc_pkg::*;
(
    // Clock
    input  wire logic                   i_ref_clk,
    // Device serial pin
    input  wire sasc_pkg::sasc_serial_t i_serial,
    // Host pins
    output sasc_pkg::sasc_pins_in_t     o_pins
);
    logic last_q = 1'b0;
    logic line;

    initial o_pins = '{sample_hold_strobe: 1'b1, sample_hold_strobe_clk: 1'b0};

    // No pull resistor: a released line shows the inverse of its last level
    always_ff @(posedge i_ref_clk)
        if (i_serial.oe)
            last_q <= i_serial.data;
    assign line = i_serial.oe ? i_serial.data : ~last_q;

    task automatic tick(input int n);
        repeat (n) @(posedge i_ref_clk);
    endtask

    task automatic strobe(input logic v);
        o_pins.sample_hold_strobe <= v;
    endtask

    // callers keep the strobe high 35 cycles before each call
    // clock stands still for many cycles before the strobe falls
    // gated clock after strobe fall, each bit taken before the next fall
    task automatic convert(input logic keep_low, input logic park,
                           output logic mark, output logic [11:0] word, output logic tail);
        mark = 1'b0;
        word = 12'h000;
        o_pins.sample_hold_strobe <= 1'b0;
        tick(2);
        for (int k = 1; k <= 14; k++)
        begin
            o_pins.sample_hold_strobe_clk <= 1'b1;
            tick(2);
            if (k == 2)
                mark = i_serial.oe & ~line;
            if (k >= 3)
                word = {word[10:0], line};
            // early rise, only after the leading bits were captured
            if (k == 7 && !keep_low)
                o_pins.sample_hold_strobe <= 1'b1;
            o_pins.sample_hold_strobe_clk <= 1'b0;
            tick(2);
        end
        tick(1);
        tail = i_serial.oe;
        // clock parks at either level between conversions
        o_pins.sample_hold_strobe_clk <= park;
    endtask
endmodule // sasc_host_model

// file: verification/tb_top.sv
// Self-checking testbench for the serial conversion controller
`timescale 1ns/1ns
module tb_top;
    import sasc_pkg::*;
    logic          i_ref_clk;
    logic          i_reset;
    logic          i_ce;
    logic [11:0]   i_sample_word;
    sasc_pins_in_t pins;
    sasc_serial_t  serial;
    logic          hold, pdown, late, mark, tail;
    logic [11:0]   word;
    int            mismatches    = 0;
    int            checked       = 0;
    logic [11:0]   words [4]     = '{12'h000, 12'hFFF, 12'hA5C, 12'h801};

    initial
    begin
        i_ref_clk = 1'b0;
        forever #5 i_ref_clk = ~i_ref_clk;
    end

    sasc_sample_hold_strobe_ctl uut (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_ce(i_ce),
        .i_pins(pins), .i_sample_word(i_sample_word), .o_serial(serial),
        .o_hold(hold), .o_power_down(pdown), .o_droop_late(late));
    sasc_host_model host (.i_ref_clk(i_ref_clk), .i_serial(serial), .o_pins(pins));

    task automatic check(input logic [11:0] got, input logic [11:0] exp);
        checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] %0t ns: seen %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic results;
        $display("mismatches %0d, checked %0d", mismatches, checked);
        if (mismatches == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Strobe fall enters hold with the clock standing still; rise aborts
    task automatic t_hold_abort;
        host.strobe(1'b0);
        host.tick(3);
        check(hold, 1'b1);
        host.strobe(1'b1);
        host.tick(3);
        check(hold, 1'b0);
        host.tick(35);
    endtask

    // Clock enable low freezes the strobe sampler
    task automatic t_ce_freeze;
        i_ce <= 1'b0;
        host.strobe(1'b0);
        host.tick(4);
        check(hold, 1'b0);
        i_ce <= 1'b1;
        host.tick(3);
        check(hold, 1'b1);
        host.strobe(1'b1);
        host.tick(36);
    endtask

    // Hold kept past the droop limit with no clock fall
    task automatic t_droop;
        host.strobe(1'b0);
        host.tick(510);
        check(late, 1'b1);
        host.strobe(1'b1);
        host.tick(36);
    endtask

    // Boundary and mixed words, clock parked low and high in turn
    task automatic t_words;
        for (int i = 0; i < 4; i++)
        begin
            i_sample_word <= words[i];
            host.tick(36);
            host.convert(1'b0, i[0], mark, word, tail);
            check(mark, 1'b1);
            check(word, words[i]);
            check(tail, 1'b0);
            check(pdown, 1'b0);
            check(late, 1'b0);
        end
    endtask

    // Strobe low through cycle thirteen, then wake and convert at once
    task automatic t_power_down;
        i_sample_word <= 12'h3C7;
        host.tick(36);
        host.convert(1'b1, 1'b0, mark, word, tail);
        check(pdown, 1'b1);
        check(word, 12'h3C7);
        host.tick(20);
        check(pdown, 1'b1);
        host.strobe(1'b1);
        host.tick(3);
        check(pdown, 1'b0);
        i_sample_word <= 12'h5A1;
        host.tick(35);
        host.convert(1'b0, 1'b1, mark, word, tail);
        check(mark, 1'b1);
        check(word, 12'h5A1);
    endtask

    initial
    begin
        i_reset       <= 1'b1;
        i_ce          <= 1'b1;
        i_sample_word <= 12'h000;
        repeat (2) @(posedge i_ref_clk);
        i_reset <= 1'b0;
        // strobe high for acquisition before first fall
        host.tick(36);
        t_hold_abort();
        t_ce_freeze();
        t_droop();
        t_words();
        t_power_down();
        results();
    end

    // Whole run needs about 1260 cycles
    initial
    begin
        #200000;
        mismatches++;
        results();
    end
endmodule // tb_top
